// >>> src/slt_pkg.sv
// constants for the lane bit-error and transport check logic
package slt_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_LANE_BERT_ENABLE  = 12'h315;
  localparam logic [11:0] ADDR_BERT_CONTROL      = 12'h316;
  localparam logic [11:0] ADDR_BERT_THR_LOW      = 12'h317;
  localparam logic [11:0] ADDR_BERT_THR_MID      = 12'h318;
  localparam logic [11:0] ADDR_BERT_THR_HIGH     = 12'h319;
  localparam logic [11:0] ADDR_BERT_ERR_LOW      = 12'h31A;
  localparam logic [11:0] ADDR_BERT_ERR_MID      = 12'h31B;
  localparam logic [11:0] ADDR_BERT_ERR_HIGH     = 12'h31C;
  localparam logic [11:0] ADDR_BERT_LANE_PASS    = 12'h31D;
  localparam logic [11:0] ADDR_TPL_CONTROL       = 12'h32C;
  localparam logic [11:0] ADDR_TPL_REF_LOW       = 12'h32D;
  localparam logic [11:0] ADDR_TPL_REF_HIGH      = 12'h32E;
  localparam logic [11:0] ADDR_TPL_RESULT        = 12'h32F;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTL_LANE_SEL_HI  = 6;
  localparam int CTL_LANE_SEL_LO  = 4;
  localparam int CTL_PAT_HI       = 3;
  localparam int CTL_PAT_LO       = 2;
  localparam int CTL_RUN_BIT      = 1;
  localparam int CTL_RESET_BIT    = 0;
  localparam int TPL_SAMPLE_HI    = 5;
  localparam int TPL_SAMPLE_LO    = 4;
  localparam int TPL_CHAN_HI      = 3;
  localparam int TPL_CHAN_LO      = 2;
  localparam int TPL_CLEAR_BIT    = 1;
  localparam int TPL_ENABLE_BIT   = 0;

  // ------------------------------------------------------------
  // reset values, sizes, codes
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [7:0]  RST_PASS      = 8'hFF;
  localparam logic [23:0] CNT_MAX       = 24'hFFFFFF;
  localparam logic [4:0]  PRIME_LEN     = 5'h1F;
  localparam int          LANES         = 8;
  localparam int          HIST_W        = 31;
  localparam int          SAMPLES       = 4;
  localparam logic [1:0]  PAT_PRBS7     = 2'h0;
  localparam logic [1:0]  PAT_PRBS15    = 2'h1;
  localparam logic [1:0]  PAT_PRBS31    = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PRIME = 2'b01,
    ST_RUN   = 2'b10
  } slt_state_t;

endpackage : slt_pkg

// >>> src/slt_link_test.sv
// lane bit-error test and short transport check with register port
// ------------------------------------------------------------
// Operation
// - eight enable bits, bit x turns on error checking of lane x.
// - pattern code 00/01/10 picks PRBS7/15/31; transmitter sends the same.
// - run bit set runs the test, cleared stops it.
// - test reset bit 1 holds state machine and all counters in reset.
// - three-bit selector picks which lane count the count registers show.
// - 24-bit writable threshold in three bytes, low, middle, high.
// - selected lane count is read-only, 24 bits, low byte first.
// - pass bit x is 1 while lane x count is below threshold.
// - two-bit field selects which sample index is checked.
// - channel field 0 picks first channel, 2 picks second.
// - writing 1 to the clear bit clears the stored result unless a mismatch is seen in the same cycle.
// - enable bit 0 disables the transport comparison.
// - chosen sample compared with 16-bit reference in two bytes.
// - mismatch flag reads 0 on match, 1 on mismatch.
// ------------------------------------------------------------
`timescale 1ns/1ps
module slt_link_test
  import slt_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // register port
  input  wire logic [11:0] REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  // lane test bits
  input  wire logic [7:0]  LANE_BIT,
  input  wire logic        LANE_VALID,
  // transport samples
  input  wire logic [63:0] CHAN0_SAMPLES,
  input  wire logic [63:0] CHAN1_SAMPLES,
  input  wire logic        SAMPLE_VALID,
  // status
  output logic      [7:0]  LANE_PASS,
  output logic             TPL_MISMATCH
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic bit_error(input logic [HIST_W-1:0] h, input logic b, input logic [1:0] pat);
    logic p;
    p = 1'b0;
    unique case (pat)
      PAT_PRBS7:  p = h[6] ^ h[5];
      PAT_PRBS15: p = h[14] ^ h[13];
      PAT_PRBS31: p = h[30] ^ h[27];
      default:    p = b;
    endcase
    return b ^ p;
  endfunction : bit_error

  function automatic logic wr_hit(input logic [11:0] a);
    return REG_WR && (REG_ADDR == a);
  endfunction : wr_hit

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0]  lane_check_enable_r;
  logic [2:0]  count_lane_select_r;
  logic [1:0]  pattern_select_r;
  logic        check_run_r;
  logic        check_reset_r;
  logic [23:0] error_limit_r;
  logic [1:0]  sample_index_select_r;
  logic [1:0]  channel_select_r;
  logic        transport_result_clear_r;
  logic        transport_check_enable_r;
  logic [15:0] reference_sample_r;
  logic [7:0]  rdata_nxt;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      lane_check_enable_r      <= RST_BYTE;
      count_lane_select_r      <= 3'h0;
      pattern_select_r         <= 2'h0;
      check_run_r              <= 1'b0;
      check_reset_r            <= 1'b0;
      error_limit_r            <= 24'h000000;
      sample_index_select_r    <= 2'h0;
      channel_select_r         <= 2'h0;
      transport_result_clear_r <= 1'b0;
      transport_check_enable_r <= 1'b0;
      reference_sample_r       <= 16'h0000;
    end else begin
      if (wr_hit(ADDR_LANE_BERT_ENABLE)) lane_check_enable_r <= REG_WDATA;
      if (wr_hit(ADDR_BERT_CONTROL)) begin
        count_lane_select_r <= REG_WDATA[CTL_LANE_SEL_HI:CTL_LANE_SEL_LO];
        pattern_select_r    <= REG_WDATA[CTL_PAT_HI:CTL_PAT_LO];
        check_run_r         <= REG_WDATA[CTL_RUN_BIT];
        check_reset_r       <= REG_WDATA[CTL_RESET_BIT];
      end
      if (wr_hit(ADDR_BERT_THR_LOW))  error_limit_r[7:0]   <= REG_WDATA;
      if (wr_hit(ADDR_BERT_THR_MID))  error_limit_r[15:8]  <= REG_WDATA;
      if (wr_hit(ADDR_BERT_THR_HIGH)) error_limit_r[23:16] <= REG_WDATA;
      if (wr_hit(ADDR_TPL_CONTROL)) begin
        sample_index_select_r    <= REG_WDATA[TPL_SAMPLE_HI:TPL_SAMPLE_LO];
        channel_select_r         <= REG_WDATA[TPL_CHAN_HI:TPL_CHAN_LO];
        transport_result_clear_r <= REG_WDATA[TPL_CLEAR_BIT];
        transport_check_enable_r <= REG_WDATA[TPL_ENABLE_BIT];
      end
      if (wr_hit(ADDR_TPL_REF_LOW))  reference_sample_r[7:0]  <= REG_WDATA;
      if (wr_hit(ADDR_TPL_REF_HIGH)) reference_sample_r[15:8] <= REG_WDATA;
    end
  end

  // ------------------------------------------------------------
  // lane test state machine
  // ------------------------------------------------------------
  slt_state_t state_r;
  logic [4:0] prime_cnt_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || check_reset_r) begin
      state_r     <= ST_IDLE;
      prime_cnt_r <= 5'h00;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          prime_cnt_r <= 5'h00;
          if (check_run_r) state_r <= ST_PRIME;
        end
        ST_PRIME: begin
          if (!check_run_r) state_r <= ST_IDLE;
          else if (LANE_VALID) begin
            prime_cnt_r <= prime_cnt_r + 5'h01;
            if (prime_cnt_r == PRIME_LEN - 5'h01) state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!check_run_r) state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // per-lane history and error counters
  // ------------------------------------------------------------
  logic [HIST_W-1:0] hist_r [LANES];
  logic [23:0]       err_cnt_r [LANES];
  logic [7:0]        pass_r;

  always_ff @(posedge CORE_CLK) begin
    for (int i = 0; i < LANES; i++) begin
      if (!RST_N) hist_r[i] <= '0;
      else if (LANE_VALID) hist_r[i] <= {hist_r[i][HIST_W-2:0], LANE_BIT[i]};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    for (int i = 0; i < LANES; i++) begin
      if (!RST_N || check_reset_r) begin
        err_cnt_r[i] <= 24'h000000;
      end else if (state_r == ST_RUN && check_run_r && LANE_VALID
                   && lane_check_enable_r[i]
                   && bit_error(hist_r[i], LANE_BIT[i], pattern_select_r)
                   && err_cnt_r[i] != CNT_MAX) begin
        err_cnt_r[i] <= err_cnt_r[i] + 24'h000001;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) pass_r <= RST_PASS;
    else begin
      for (int i = 0; i < LANES; i++) begin
        pass_r[i] <= (err_cnt_r[i] < error_limit_r);
      end
    end
  end

  assign LANE_PASS = pass_r;

  // ------------------------------------------------------------
  // short transport check
  // ------------------------------------------------------------
  logic [63:0] chan_word;
  logic [15:0] picked_sample;
  logic        mismatch_r;
  logic        mismatch_event;
  logic        clear_event;

  assign chan_word      = channel_select_r[1] ? CHAN1_SAMPLES : CHAN0_SAMPLES;
  assign picked_sample  = chan_word[16*sample_index_select_r +: 16];
  assign mismatch_event = transport_check_enable_r && SAMPLE_VALID
                          && (picked_sample != reference_sample_r);
  assign clear_event    = wr_hit(ADDR_TPL_CONTROL) && REG_WDATA[TPL_CLEAR_BIT];

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) mismatch_r <= 1'b0;
    else if (mismatch_event) mismatch_r <= 1'b1;
    else if (clear_event) mismatch_r <= 1'b0;
  end

  assign TPL_MISMATCH = mismatch_r;

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  logic [23:0] sel_cnt;
  logic [7:0]  rdata_r;

  assign sel_cnt = err_cnt_r[count_lane_select_r];

  always_comb begin
    rdata_nxt = 8'h00;
    unique case (REG_ADDR)
      ADDR_LANE_BERT_ENABLE: rdata_nxt = lane_check_enable_r;
      ADDR_BERT_CONTROL:     rdata_nxt = {1'b0, count_lane_select_r, pattern_select_r, check_run_r, check_reset_r};
      ADDR_BERT_THR_LOW:     rdata_nxt = error_limit_r[7:0];
      ADDR_BERT_THR_MID:     rdata_nxt = error_limit_r[15:8];
      ADDR_BERT_THR_HIGH:    rdata_nxt = error_limit_r[23:16];
      ADDR_BERT_ERR_LOW:     rdata_nxt = sel_cnt[7:0];
      ADDR_BERT_ERR_MID:     rdata_nxt = sel_cnt[15:8];
      ADDR_BERT_ERR_HIGH:    rdata_nxt = sel_cnt[23:16];
      ADDR_BERT_LANE_PASS:   rdata_nxt = pass_r;
      ADDR_TPL_CONTROL:      rdata_nxt = {2'h0, sample_index_select_r, channel_select_r,
                                          transport_result_clear_r, transport_check_enable_r};
      ADDR_TPL_REF_LOW:      rdata_nxt = reference_sample_r[7:0];
      ADDR_TPL_REF_HIGH:     rdata_nxt = reference_sample_r[15:8];
      ADDR_TPL_RESULT:       rdata_nxt = {7'h00, mismatch_r};
      default:               rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) rdata_r <= 8'h00;
    else if (REG_RD) rdata_r <= rdata_nxt;
  end

  assign REG_RDATA = rdata_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_lane_off_holds;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (!lane_check_enable_r[1] && !check_reset_r) |=> (err_cnt_r[1] == $past(err_cnt_r[1]));
  endproperty
  a_lane_off_holds: assert property (p_lane_off_holds) else $error("disabled lane counted");

  property p_stop_holds;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (!check_run_r && !check_reset_r) |=> $stable(err_cnt_r[0]);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("stopped test counted");

  property p_reset_clears;
    @(posedge CORE_CLK) disable iff (!RST_N)
    check_reset_r |=> (err_cnt_r[2] == 24'h000000 && state_r == ST_IDLE);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("test reset did not clear");

  property p_prbs7_clean;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (pattern_select_r == PAT_PRBS7 && (LANE_BIT[0] == (hist_r[0][6] ^ hist_r[0][5])) && !check_reset_r)
      |=> $stable(err_cnt_r[0]);
  endproperty
  a_prbs7_clean: assert property (p_prbs7_clean) else $error("good prbs7 bit counted");

  property p_pass_flag;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (err_cnt_r[2] >= error_limit_r) ##1 $stable(err_cnt_r[2]) && $stable(error_limit_r) |-> !pass_r[2];
  endproperty
  a_pass_flag: assert property (p_pass_flag) else $error("pass flag set at threshold");

  property p_read_count;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (REG_RD && REG_ADDR == ADDR_BERT_ERR_MID) |=> (REG_RDATA == $past(sel_cnt[15:8]));
  endproperty
  a_read_count: assert property (p_read_count) else $error("count byte read wrong");

  property p_thr_write;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (REG_WR && REG_ADDR == ADDR_BERT_THR_HIGH) |=> (error_limit_r[23:16] == $past(REG_WDATA));
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("threshold high byte not stored");

  property p_tpl_clear;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (clear_event && !mismatch_event) |=> !TPL_MISMATCH;
  endproperty
  a_tpl_clear: assert property (p_tpl_clear) else $error("result not cleared");

  property p_tpl_set;
    @(posedge CORE_CLK) disable iff (!RST_N)
    mismatch_event |=> TPL_MISMATCH ##1 (TPL_MISMATCH || $past(clear_event));
  endproperty
  a_tpl_set: assert property (p_tpl_set) else $error("mismatch not flagged");

  property p_tpl_off;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (!transport_check_enable_r && !TPL_MISMATCH) |=> !TPL_MISMATCH;
  endproperty
  a_tpl_off: assert property (p_tpl_off) else $error("disabled check flagged");

  property p_enable_write;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (REG_WR && REG_ADDR == ADDR_LANE_BERT_ENABLE) |=> (lane_check_enable_r == $past(REG_WDATA));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("lane enable not stored");

  property p_run_starts;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (state_r == ST_IDLE && check_run_r && !check_reset_r) |=> (state_r == ST_PRIME);
  endproperty
  a_run_starts: assert property (p_run_starts) else $error("run bit did not start test");

  property p_run_stops;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (state_r != ST_IDLE && !check_run_r) |=> (state_r == ST_IDLE);
  endproperty
  a_run_stops: assert property (p_run_stops) else $error("cleared run bit did not stop test");

  property p_pass_below;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (err_cnt_r[0] < error_limit_r) |=> pass_r[0];
  endproperty
  a_pass_below: assert property (p_pass_below) else $error("pass flag low below threshold");

  property p_result_read;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (REG_RD && REG_ADDR == ADDR_TPL_RESULT) |=> (REG_RDATA == {7'h00, $past(TPL_MISMATCH)});
  endproperty
  a_result_read: assert property (p_result_read) else $error("mismatch flag read wrong");

  property p_chan1_pick;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (transport_check_enable_r && SAMPLE_VALID && channel_select_r == 2'h2 && sample_index_select_r == 2'h0
     && CHAN1_SAMPLES[15:0] != reference_sample_r) |=> TPL_MISMATCH;
  endproperty
  a_chan1_pick: assert property (p_chan1_pick) else $error("second channel mismatch missed");

endmodule : slt_link_test

// >>> tb/slt_prbs_tx.sv
// transmitter model that drives test patterns onto the eight lanes
`timescale 1ns/1ps
module slt_prbs_tx
  import slt_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control from bench
  input  wire logic       send,
  input  wire logic [1:0] pat,
  input  wire logic [7:0] flip,
  // lanes
  output logic      [7:0] lane_bit,
  output logic            lane_valid
);
  logic [30:0] hist_r;
  logic        bit_nxt;

  // ------------------------------------------------------------
  // pattern recurrence, h0 is the previous bit
  // ------------------------------------------------------------
  always_comb begin
    case (pat)
      PAT_PRBS15: bit_nxt = hist_r[14] ^ hist_r[13];
      PAT_PRBS31: bit_nxt = hist_r[30] ^ hist_r[27];
      default:    bit_nxt = hist_r[6] ^ hist_r[5];
    endcase
  end

  // ------------------------------------------------------------
  // lane drive, idle lanes toggle
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hist_r     <= 31'h7FFFFFFF;
      lane_bit   <= 8'h00;
      lane_valid <= 1'b0;
    end else begin
      lane_valid <= send;
      if (send) begin
        hist_r   <= {hist_r[29:0], bit_nxt};
        lane_bit <= {8{bit_nxt}} ^ flip;
      end else begin
        lane_bit <= ~lane_bit;
      end
    end
  end
endmodule : slt_prbs_tx

// >>> tb/slt_link_test_tb_top.sv
// bench for the lane bit-error and transport check block
`timescale 1ns/1ps
module slt_link_test_tb_top;
  import slt_pkg::*;
  logic        CORE_CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [11:0] REG_ADDR = 12'h000;
  logic        REG_WR = 1'b0;
  logic [7:0]  REG_WDATA = 8'h00;
  logic        REG_RD = 1'b0;
  logic [7:0]  REG_RDATA;
  logic [7:0]  LANE_BIT;
  logic        LANE_VALID;
  logic [63:0] CHAN0_SAMPLES = 64'h4D44_3C33_2B22_1A11;
  logic [63:0] CHAN1_SAMPLES = 64'h9E88_8F77_7E66_6D55;
  logic        SAMPLE_VALID = 1'b0;
  logic [7:0]  LANE_PASS;
  logic        TPL_MISMATCH;
  logic        send = 1'b0;
  logic [1:0]  pat = 2'h0;
  logic [7:0]  flip = 8'h00;
  logic [15:0] smp;
  int          mismatches = 0;
  int          check_count = 0;

  always #2 CORE_CLK = ~CORE_CLK;

  slt_link_test uut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .LANE_BIT(LANE_BIT),
    .LANE_VALID(LANE_VALID), .CHAN0_SAMPLES(CHAN0_SAMPLES), .CHAN1_SAMPLES(CHAN1_SAMPLES),
    .SAMPLE_VALID(SAMPLE_VALID), .LANE_PASS(LANE_PASS), .TPL_MISMATCH(TPL_MISMATCH));

  slt_prbs_tx u_tx (.clk(CORE_CLK), .rst_n(RST_N), .send(send), .pat(pat), .flip(flip),
    .lane_bit(LANE_BIT), .lane_valid(LANE_VALID));

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge CORE_CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD   <= 1'b0;
    #1 chk(REG_RDATA, e);
  endtask : rd

  task automatic bits(input int n, input logic [7:0] m);
    for (int i = 0; i < n; i++) begin
      @(posedge CORE_CLK);
      send <= 1'b1;
      flip <= (i == 0) ? m : 8'h00;
    end
    @(posedge CORE_CLK);
    send <= 1'b0;
    flip <= 8'h00;
  endtask : bits

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  initial begin
    #40000;
    mismatches++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (11) @(posedge CORE_CLK);
    #1 chk(LANE_PASS, RST_PASS);
    chk({7'h00, TPL_MISMATCH}, 8'h00);
    @(posedge CORE_CLK);
    RST_N <= 1'b1;
    rd(ADDR_BERT_CONTROL, 8'h00);
    rd(ADDR_BERT_LANE_PASS, 8'h00);
    rd(ADDR_TPL_RESULT, 8'h00);
    rd(12'h300, 8'h00);
    for (int i = 0; i < 6; i++) begin
      logic [11:0] a;
      a = (i < 4) ? ((i == 0) ? ADDR_LANE_BERT_ENABLE : ADDR_BERT_THR_LOW + 12'(i - 1)) : ADDR_TPL_REF_LOW + 12'(i - 4);
      rd(a, 8'h00);
      wr(a, 8'hA5);
      rd(a, 8'hA5);
    end
    wr(ADDR_BERT_ERR_LOW, 8'h55);
    rd(ADDR_BERT_ERR_LOW, 8'h00);
    wr(ADDR_BERT_CONTROL, 8'hFC);
    rd(ADDR_BERT_CONTROL, 8'h7C);
    wr(ADDR_TPL_CONTROL, 8'hFE);
    rd(ADDR_TPL_CONTROL, 8'h3E);
    $display("test registers done");
    wr(ADDR_LANE_BERT_ENABLE, 8'h05);
    wr(ADDR_BERT_THR_LOW, 8'h04);
    wr(ADDR_BERT_THR_MID, 8'h00);
    wr(ADDR_BERT_THR_HIGH, 8'h00);
    for (int p = 0; p < 3; p++) begin
      pat <= 2'(p);
      wr(ADDR_BERT_CONTROL, {1'b0, 3'd2, 2'(p), 2'b01});
      rd(ADDR_BERT_ERR_LOW, 8'h00);
      wr(ADDR_BERT_CONTROL, {1'b0, 3'd2, 2'(p), 2'b10});
      bits(60, 8'h00);
      bits(40, 8'h07);
      rd(ADDR_BERT_ERR_LOW, 8'h03);
      rd(ADDR_BERT_LANE_PASS, 8'hFF);
      bits(40, 8'h07);
      rd(ADDR_BERT_ERR_LOW, 8'h06);
      chk(LANE_PASS, 8'hFA);
      wr(ADDR_BERT_CONTROL, {1'b0, 3'd1, 2'(p), 2'b10});
      rd(ADDR_BERT_ERR_LOW, 8'h00);
      wr(ADDR_BERT_CONTROL, {1'b0, 3'd0, 2'(p), 2'b10});
      rd(ADDR_BERT_ERR_LOW, 8'h06);
      rd(ADDR_BERT_ERR_MID, 8'h00);
      rd(ADDR_BERT_ERR_HIGH, 8'h00);
    end
    wr(ADDR_BERT_THR_MID, 8'h01);
    rd(ADDR_BERT_LANE_PASS, 8'hFF);
    wr(ADDR_BERT_CONTROL, 8'h08);
    bits(20, 8'h01);
    rd(ADDR_BERT_ERR_LOW, 8'h06);
    $display("test lane check done");
    @(posedge CORE_CLK);
    SAMPLE_VALID <= 1'b1;
    for (int c = 0; c < 4; c += 2) begin
      for (int k = 0; k < 4; k++) begin
        smp = 16'(((c == 2) ? CHAN1_SAMPLES : CHAN0_SAMPLES) >> (16 * k));
        wr(ADDR_TPL_CONTROL, {2'b00, 2'(k), 2'(c), 2'b10});
        wr(ADDR_TPL_REF_LOW, smp[7:0]);
        wr(ADDR_TPL_REF_HIGH, smp[15:8] ^ 8'h01);
        rd(ADDR_TPL_RESULT, 8'h00);
        wr(ADDR_TPL_CONTROL, {2'b00, 2'(k), 2'(c), 2'b01});
        rd(ADDR_TPL_RESULT, 8'h01);
        wr(ADDR_TPL_REF_HIGH, smp[15:8]);
        rd(ADDR_TPL_RESULT, 8'h01);
        wr(ADDR_TPL_CONTROL, {2'b00, 2'(k), 2'(c), 2'b11});
        rd(ADDR_TPL_RESULT, 8'h00);
        chk({7'h00, TPL_MISMATCH}, 8'h00);
      end
    end
    $display("test transport check done");
    tally_and_finish();
  end
endmodule : slt_link_test_tb_top
